// ===== rtl/hmp_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants for the host mailbox port
// ----------------------------------------------------------------------------
package hmp_pkg;
  // Mailbox geometry and register indices (core side and host side alike).
  localparam int         NDR       = 6;
  localparam int         BYTE_W    = 8;
  localparam logic [3:0] DR_LAST   = 4'h5;
  localparam logic [3:0] A_STAT_LO = 4'h6;
  localparam logic [3:0] A_STAT_HI = 4'h7;
  localparam logic [3:0] A_MASK    = 4'h8;
  localparam logic [3:0] A_CFG     = 4'h8;
  // Field positions: write flags and write masks low, read flags and masks high.
  localparam int WF_LSB   = 0;
  localparam int RF_LSB   = 8;
  localparam int SRST_BIT = 0;
  // Host configuration register bits that drive the strap pins.
  localparam int CFG_W16   = 0;
  localparam int CFG_STYLE = 1;
  localparam int CFG_MUX   = 2;
  localparam int CFG_W     = 3;
  // Synchroniser bundle layout: ale, rd/rw, wr/ds, address, data.
  localparam int SB_W    = 22;
  localparam int SB_ALE  = 21;
  localparam int SB_RDRW = 20;
  localparam int SB_WRDS = 19;
  localparam int SB_A_HI = 18;
  localparam int SB_A_LO = 16;
  localparam int SB_D_HI = 15;
  // Timing in clock cycles of the 100 MHz clock.
  localparam logic [4:0] SRST_CYC  = 5'h10;
  localparam logic [3:0] SETUP_CYC = 4'h3;
  localparam logic [3:0] HOLD_CYC  = 4'h8;
  localparam logic [3:0] GAP_CYC   = 4'h6;
  // Device start-up sequence.
  typedef enum logic [2:0] {
    BT_STRAP = 3'b001,
    BT_HOST  = 3'b010,
    BT_RUN   = 3'b100
  } hmp_boot_e;
  // Host pin-cycle sequencer.
  typedef enum logic [5:0] {
    H_IDLE   = 6'b000001,
    H_ALE    = 6'b000010,
    H_SETUP  = 6'b000100,
    H_STROBE = 6'b001000,
    H_GAP    = 6'b010000,
    H_ACK    = 6'b100000
  } hmp_hst_e;
endpackage

// ===== rtl/hmp_if.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host port pins; each data direction has its own lines and its own enable
// ----------------------------------------------------------------------------
interface hmp_if;
  logic        width16;
  logic        strobe_style;
  logic        bus_mux;
  logic        ale;
  logic        rd_rw;
  logic        wr_ds_n;
  logic [2:0]  addr;
  logic [15:0] hd_h2d;
  logic        hd_h2d_oe;
  logic [15:0] hd_d2h;
  logic        hd_d2h_oe;
  modport host (output width16, strobe_style, bus_mux, ale, rd_rw, wr_ds_n, addr, hd_h2d,
                hd_h2d_oe, input hd_d2h, hd_d2h_oe);
  modport device (input width16, strobe_style, bus_mux, ale, rd_rw, wr_ds_n, addr, hd_h2d,
                  hd_h2d_oe, output hd_d2h, hd_d2h_oe);
endinterface

// ===== rtl/hmp_device.sv
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Behaviour
// - Host strobes accepted asynchronously, any time.
// - Host writes never stall the core.
// - Width pin selects 8- or 16-bit transfers.
// - Style pin selects split or rw/ds strobes.
// - Mux pin selects split or ALE-multiplexed bus.
// - Six data, two status, one mask register.
// - Data registers mapped in core data space.
// - Status registers readable by core and host.
// - Upper status holds software reset, both set.
// - Host write raises write interrupt request.
// - Completed host read raises read interrupt.
// - Per-register read and write status flags.
// - Per-register per-direction interrupt mask bits.
// - Interrupt needs both mask and global enable.
// - Host boot moves opcodes into program memory.
// - Boot pin picks host or external boot.
// - Force/clear cannot touch mailbox interrupts.
module hmp_device
  import hmp_pkg::*;
#(
  parameter logic [7:0] BOOT_WORDS = 8'h20
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Host pins
  hmp_if.device            hp,
  // Core data-memory window
  input  wire logic [3:0]  core_addr,
  input  wire logic        core_we,
  input  wire logic        core_re,
  input  wire logic [15:0] core_wdata,
  output logic      [15:0] core_rdata,
  // Global enables from the core interrupt mask, and requests to the core
  input  wire logic        core_wr_irq_en,
  input  wire logic        core_rd_irq_en,
  output logic             wr_irq_req,
  output logic             rd_irq_req,
  output logic             core_soft_rst,
  // Boot control and program-memory load port
  input  wire logic        boot_source_select,
  output logic             boot_busy,
  output logic             boot_from_ext,
  output logic             pm_we,
  output logic      [7:0]  pm_addr,
  output logic      [15:0] pm_data
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [SB_W-1:0] sy1;
  logic [SB_W-1:0] sy2;
  logic            rd_q;
  logic            wr_q;
  logic            ale_q;
  logic            rd_s;
  logic            wr_s;
  logic            ale_s;
  logic [15:0]     hdat;
  logic [CFG_W:0]  strap1;
  logic [CFG_W:0]  strap2;

  // Rest level of the bundle: both strobes high, so leaving reset makes no false edge.
  localparam logic [SB_W-1:0] SB_REST = SB_W'((1 << SB_RDRW) | (1 << SB_WRDS));

  // Straps and the boot pin, boot just above the host straps. These flops skip
  // reset so the boot pin has settled by the first edge after reset.
  always_ff @(posedge clk) begin
    strap1 <= {boot_source_select, hp.bus_mux, hp.strobe_style, hp.width16};
    strap2 <= strap1;
  end

  // Every pin, strobes and data alike, passes two flops before use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sy1   <= SB_REST;
      sy2   <= SB_REST;
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      ale_q <= 1'b0;
    end else begin
      sy1   <= {hp.ale, hp.rd_rw, hp.wr_ds_n, hp.addr, hp.hd_h2d};
      sy2   <= sy1;
      rd_q  <= rd_s;
      wr_q  <= wr_s;
      ale_q <= ale_s;
    end
  end

  // Strobe decode: split active-low strobes, or rw level plus data strobe.
  always_comb begin
    hdat  = sy2[SB_D_HI:0];
    ale_s = sy2[SB_ALE];
    if (strap2[CFG_STYLE]) begin
      rd_s = ~sy2[SB_WRDS] & sy2[SB_RDRW];
      wr_s = ~sy2[SB_WRDS] & ~sy2[SB_RDRW];
    end else begin
      rd_s = ~sy2[SB_RDRW];
      wr_s = ~sy2[SB_WRDS];
    end
  end

  // --------------------------------------------------------------------------
  // Mailbox state
  // --------------------------------------------------------------------------
  logic [15:0]     dr [NDR];
  logic [15:0]     next_dr [NDR];
  logic [NDR-1:0]  wflag, next_wflag, rflag, next_rflag;
  logic [15:0]     mask, next_mask;
  logic            srst, next_srst;
  logic [4:0]      srst_cnt, next_srst_cnt;
  logic [2:0]      alat, next_alat;
  logic            byte_hi, next_byte_hi;
  logic [7:0]      lo_tmp, next_lo_tmp;
  logic [15:0]     next_core_rdata, next_d2h;
  logic            next_d2h_oe, next_wr_irq, next_rd_irq, next_soft_rst;
  hmp_boot_e       bst, next_bst;
  logic            next_boot_ext, next_pm_we;
  logic [7:0]      next_pm_addr;
  logic [15:0]     next_pm_data;
  logic [2:0]      haddr;
  logic [15:0]     hword;
  logic [15:0]     hview;
  logic            w8;

  // Register read view shared by core and host, so both see one status.
  function automatic logic [15:0] reg_view(input logic [3:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a <= DR_LAST) begin
      v = dr[a[2:0]];
    end else if (a == A_STAT_LO) begin
      v[WF_LSB +: NDR] = wflag;
      v[RF_LSB +: NDR] = rflag;
    end else if (a == A_STAT_HI) begin
      v[SRST_BIT] = srst;
    end else if (a == A_MASK) begin
      v = mask;
    end
    return v;
  endfunction

  // One next-state process for the whole mailbox. Order matters: the core
  // side is applied first so a host event in the same cycle wins.
  always_comb begin
    next_dr         = dr;
    next_wflag      = wflag;
    next_rflag      = rflag;
    next_mask       = mask;
    next_srst       = srst;
    next_srst_cnt   = srst_cnt;
    next_alat       = alat;
    next_byte_hi    = byte_hi;
    next_lo_tmp     = lo_tmp;
    next_core_rdata = core_rdata;
    next_d2h        = hp.hd_d2h;
    next_d2h_oe     = hp.hd_d2h_oe;
    next_wr_irq     = 1'b0;
    next_rd_irq     = 1'b0;
    next_soft_rst   = 1'b0;
    next_bst        = bst;
    next_boot_ext   = boot_from_ext;
    next_pm_we      = 1'b0;
    next_pm_addr    = pm_addr;
    next_pm_data    = pm_data;
    w8              = ~strap2[CFG_W16];
    haddr           = strap2[CFG_MUX] ? alat : sy2[SB_A_HI:SB_A_LO];
    hview           = reg_view({1'b0, haddr});
    hword           = w8 ? {hdat[BYTE_W-1:0], lo_tmp} : hdat;
    // Soft reset holds the core in reset for a fixed time, then clears.
    if (srst) begin
      next_soft_rst = 1'b1;
      next_srst_cnt = srst_cnt + 5'h01;
      if (srst_cnt == SRST_CYC - 5'h01) begin
        next_srst     = 1'b0;
        next_srst_cnt = 5'h00;
      end
    end
    // Boot source strap is caught once, on the first cycle after reset.
    case (bst)
      BT_STRAP: begin
        next_bst      = strap2[CFG_W] ? BT_HOST : BT_RUN;
        next_boot_ext = ~strap2[CFG_W];
      end
      BT_HOST:  next_bst = bst;
      BT_RUN:   next_boot_ext = 1'b0;
      default:  next_bst = BT_STRAP;
    endcase
    // Core loads and stores; a load consumes the write flag, a store the read flag.
    if (core_re) begin
      next_core_rdata = reg_view(core_addr);
      if (core_addr <= DR_LAST) next_wflag[core_addr[2:0]] = 1'b0;
    end
    if (core_we) begin
      if (core_addr <= DR_LAST) begin
        next_dr[core_addr[2:0]]    = core_wdata;
        next_rflag[core_addr[2:0]] = 1'b0;
      end else if (core_addr == A_MASK) begin
        next_mask = core_wdata;
      end else if (core_addr == A_STAT_HI && core_wdata[SRST_BIT]) begin
        next_srst = 1'b1;
      end
    end
    // Multiplexed bus: address taken as ALE falls.
    if (ale_q && !ale_s) next_alat = hdat[SB_A_HI-SB_A_LO:0];
    // Host read: drive on strobe start, count completion on strobe release.
    if (rd_s && !rd_q) begin
      next_d2h    = (w8 && byte_hi) ? {8'h00, hview[15:BYTE_W]} : hview;
      next_d2h_oe = 1'b1;
    end
    if (rd_q && !rd_s) begin
      next_d2h_oe  = 1'b0;
      next_byte_hi = w8 & ~byte_hi;
      if ((!w8 || byte_hi) && {1'b0, haddr} <= DR_LAST && bst == BT_RUN) begin
        next_rflag[haddr] = 1'b1;
        next_rd_irq = mask[RF_LSB + haddr] & core_rd_irq_en;
      end
    end
    // Host write: data latched at the trailing edge of the strobe.
    if (wr_q && !wr_s) begin
      next_byte_hi = w8 & ~byte_hi;
      if (w8 && !byte_hi) begin
        next_lo_tmp = hdat[BYTE_W-1:0];
      end else if ({1'b0, haddr} <= DR_LAST) begin
        if (bst == BT_HOST) begin
          // Each boot opcode goes straight to program memory.
          next_pm_we   = 1'b1;
          next_pm_data = hword;
          if (pm_addr == BOOT_WORDS - 8'h01) next_bst = BT_RUN;
        end else begin
          next_dr[haddr]    = hword;
          next_wflag[haddr] = 1'b1;
          next_wr_irq = mask[WF_LSB + haddr] & core_wr_irq_en;
        end
      end else if ({1'b0, haddr} == A_STAT_HI && hword[SRST_BIT]) begin
        next_srst = 1'b1;
      end
    end
    if (pm_we) next_pm_addr = pm_addr + 8'h01;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NDR; i++) dr[i] <= 16'h0000;
      wflag         <= '0;
      rflag         <= '0;
      mask          <= 16'h0000;
      srst          <= 1'b0;
      srst_cnt      <= 5'h00;
      alat          <= 3'h0;
      byte_hi       <= 1'b0;
      lo_tmp        <= 8'h00;
      core_rdata    <= 16'h0000;
      hp.hd_d2h     <= 16'h0000;
      hp.hd_d2h_oe  <= 1'b0;
      wr_irq_req    <= 1'b0;
      rd_irq_req    <= 1'b0;
      core_soft_rst <= 1'b0;
      bst           <= BT_STRAP;
      boot_busy     <= 1'b0;
      boot_from_ext <= 1'b0;
      pm_we         <= 1'b0;
      pm_addr       <= 8'h00;
      pm_data       <= 16'h0000;
    end else begin
      dr            <= next_dr;
      wflag         <= next_wflag;
      rflag         <= next_rflag;
      mask          <= next_mask;
      srst          <= next_srst;
      srst_cnt      <= next_srst_cnt;
      alat          <= next_alat;
      byte_hi       <= next_byte_hi;
      lo_tmp        <= next_lo_tmp;
      core_rdata    <= next_core_rdata;
      hp.hd_d2h     <= next_d2h;
      hp.hd_d2h_oe  <= next_d2h_oe;
      wr_irq_req    <= next_wr_irq;
      rd_irq_req    <= next_rd_irq;
      core_soft_rst <= next_soft_rst;
      bst           <= next_bst;
      boot_busy     <= (next_bst == BT_HOST);
      boot_from_ext <= next_boot_ext;
      pm_we         <= next_pm_we;
      pm_addr       <= next_pm_addr;
      pm_data       <= next_pm_data;
    end
  end
endmodule

// ===== rtl/hmp_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Host end: Avalon-MM slave that runs mailbox cycles on the host pins
// ----------------------------------------------------------------------------
module hmp_host
  import hmp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Host pins
  hmp_if.host              hp
);
  hmp_hst_e     st, next_st;
  logic [3:0]   cnt, next_cnt;
  logic         phase, next_phase;
  logic [15:0]  rd_word, next_rd_word;
  logic [15:0]  d2h_s1, d2h_s2;
  logic [CFG_W-1:0] cfg, next_cfg;
  logic [31:0]  next_rdata;
  logic         next_ale, next_rdrw, next_wrds_n, next_oe, next_wait;
  logic [2:0]   next_addr;
  logic [15:0]  next_h2d;
  logic         is_rd, strobe;

  // Device read data crosses into this clock through two flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      d2h_s1 <= 16'h0000;
      d2h_s2 <= 16'h0000;
    end else begin
      d2h_s1 <= hp.hd_d2h;
      d2h_s2 <= d2h_s1;
    end
  end

  // One access: optional ALE phase, setup, strobe, gap, and a second byte
  // in 8-bit mode. Cycles are long enough for the device synchronisers.
  always_comb begin
    next_st      = st;
    next_cnt     = cnt + 4'h1;
    next_phase   = phase;
    next_rd_word = rd_word;
    next_cfg     = cfg;
    next_rdata   = avs_readdata;
    next_ale     = 1'b0;
    next_addr    = hp.addr;
    next_h2d     = hp.hd_h2d;
    next_oe      = 1'b0;
    next_wait    = 1'b1;
    is_rd        = avs_read;
    strobe       = 1'b0;
    case (st)
      H_IDLE: begin
        next_cnt   = 4'h0;
        next_phase = 1'b0;
        if ((avs_read || avs_write) && avs_address == A_CFG) begin
          if (avs_write) next_cfg = avs_writedata[CFG_W-1:0];
          next_rdata = {29'h0, cfg};
          next_wait  = 1'b0;
          next_st    = H_ACK;
        end else if (avs_read || avs_write) begin
          next_addr = avs_address[2:0];
          next_st   = cfg[CFG_MUX] ? H_ALE : H_SETUP;
        end
      end
      H_ALE: begin
        next_ale = 1'b1;
        next_oe  = 1'b1;
        next_h2d = {13'h0, avs_address[2:0]};
        if (cnt == SETUP_CYC) begin
          next_cnt = 4'h0;
          next_st  = H_SETUP;
        end
      end
      H_SETUP: begin
        next_oe = cfg[CFG_MUX];
        if (cnt == SETUP_CYC) begin
          next_cnt = 4'h0;
          next_st  = H_STROBE;
        end
      end
      H_STROBE: begin
        strobe   = 1'b1;
        next_oe  = ~is_rd;
        next_h2d = (cfg[CFG_W16]) ? avs_writedata[15:0] :
                   {8'h00, phase ? avs_writedata[15:BYTE_W] : avs_writedata[BYTE_W-1:0]};
        if (cnt == HOLD_CYC) begin
          if (phase) next_rd_word = {d2h_s2[BYTE_W-1:0], rd_word[BYTE_W-1:0]};
          else       next_rd_word = d2h_s2;
          next_cnt = 4'h0;
          next_st  = H_GAP;
        end
      end
      H_GAP: begin
        next_oe = ~is_rd;
        if (cnt == GAP_CYC) begin
          next_cnt = 4'h0;
          if (!cfg[CFG_W16] && !phase) begin
            next_phase = 1'b1;
            next_st    = H_STROBE;
          end else begin
            next_rdata = {16'h0000, rd_word};
            next_wait  = 1'b0;
            next_st    = H_ACK;
          end
        end
      end
      // Waitrequest is low for this whole cycle, so the transfer ends at the
      // edge that leaves it and a held request is never taken twice.
      H_ACK: begin
        next_st = H_IDLE;
      end
      default: next_st = H_IDLE;
    endcase
    // Strobe scheme chosen by the style strap.
    if (cfg[CFG_STYLE]) begin
      next_rdrw   = (st == H_IDLE || st == H_ACK) ? 1'b1 : is_rd;
      next_wrds_n = ~strobe;
    end else begin
      next_rdrw   = ~(strobe & is_rd);
      next_wrds_n = ~(strobe & ~is_rd);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st              <= H_IDLE;
      cnt             <= 4'h0;
      phase           <= 1'b0;
      rd_word         <= 16'h0000;
      cfg             <= '0;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      hp.width16      <= 1'b0;
      hp.strobe_style <= 1'b0;
      hp.bus_mux      <= 1'b0;
      hp.ale          <= 1'b0;
      hp.rd_rw        <= 1'b1;
      hp.wr_ds_n      <= 1'b1;
      hp.addr         <= 3'h0;
      hp.hd_h2d       <= 16'h0000;
      hp.hd_h2d_oe    <= 1'b0;
    end else begin
      st              <= next_st;
      cnt             <= next_cnt;
      phase           <= next_phase;
      rd_word         <= next_rd_word;
      cfg             <= next_cfg;
      avs_readdata    <= next_rdata;
      avs_waitrequest <= next_wait;
      hp.width16      <= cfg[CFG_W16];
      hp.strobe_style <= cfg[CFG_STYLE];
      hp.bus_mux      <= cfg[CFG_MUX];
      hp.ale          <= next_ale;
      hp.rd_rw        <= next_rdrw;
      hp.wr_ds_n      <= next_wrds_n;
      hp.addr         <= next_addr;
      hp.hd_h2d       <= next_h2d;
      hp.hd_h2d_oe    <= next_oe;
    end
  end
endmodule

// ===== verif/hmp_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Pin-level checks on the wires between the two ends
// ----------------------------------------------------------------------------
module hmp_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Host pins
  input wire logic        width16,
  input wire logic        strobe_style,
  input wire logic        bus_mux,
  input wire logic        ale,
  input wire logic        rd_rw,
  input wire logic        wr_ds_n,
  input wire logic [2:0]  addr,
  input wire logic [15:0] hd_h2d,
  input wire logic        hd_h2d_oe,
  input wire logic [15:0] hd_d2h,
  input wire logic        hd_d2h_oe
);
  logic rd_act;
  logic wr_act;
  logic strobe;

  // Decode read and write strobes from the selected scheme.
  assign rd_act = strobe_style ? (rd_rw && !wr_ds_n) : !rd_rw;
  assign wr_act = strobe_style ? (!rd_rw && !wr_ds_n) : !wr_ds_n;
  assign strobe = rd_act || wr_act;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Only one end may drive the data lines at a time.
  bus_owner_a: assert property (!(hd_h2d_oe && hd_d2h_oe))
    else $error("Both ends drive the data lines.");
  split_strobes_a: assert property (!strobe_style |-> (rd_rw || wr_ds_n))
    else $error("Read and write strobes active together.");
  ale_mux_a: assert property (ale |-> bus_mux && hd_h2d_oe)
    else $error("Address latch pulse outside multiplexed mode.");
  addr_hold_a: assert property (strobe && !bus_mux |-> $stable(addr))
    else $error("Address moved during a strobe.");
  strap_hold_a: assert property (strobe |-> $stable({width16, strobe_style, bus_mux}))
    else $error("Strap pins moved during a strobe.");
  // A short strobe could slip past the two-flop synchroniser.
  strobe_width_a: assert property ($rose(strobe) |-> strobe [*8])
    else $error("Strobe shorter than eight cycles.");
  wr_data_a: assert property (wr_act && $past(wr_act) |-> hd_h2d_oe && $stable(hd_h2d))
    else $error("Write data not held during the strobe.");
  wr_after_a: assert property ($fell(wr_act) |-> (hd_h2d_oe && $stable(hd_h2d)) [*3])
    else $error("Write data dropped before capture.");
  rd_drive_a: assert property (rd_act [*8] |-> hd_d2h_oe)
    else $error("Device not driving read data.");
  rd_release_a: assert property ($fell(rd_act) |-> ##[1:7] !hd_d2h_oe)
    else $error("Device kept driving after read.");
  idle_quiet_a: assert property (!rd_act [*8] |-> !hd_d2h_oe)
    else $error("Device drives data with no read.");
endmodule

// ===== verif/host_mailbox_port_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Bench: Avalon host end facing the device end
// ----------------------------------------------------------------------------
module host_mailbox_port_tb
  import hmp_pkg::*;
;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  core_addr = 4'h0;
  logic        core_we = 1'h0;
  logic        core_re = 1'h0;
  logic [15:0] core_wdata = 16'h0;
  logic [15:0] core_rdata;
  logic        wen = 1'h0;
  logic        ren = 1'h0;
  logic        wr_irq_req;
  logic        rd_irq_req;
  logic        core_soft_rst;
  logic        boot_sel = 1'h0;
  logic        boot_busy;
  logic        boot_ext;
  int          ext_cyc = 0;
  logic        pm_we;
  logic [7:0]  pm_addr;
  logic [15:0] pm_data;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          wr_irqs = 0;
  int          rd_irqs = 0;
  int          srst_cyc = 0;
  logic [23:0] pm_q[$];

  always #5 clk = ~clk;

  hmp_if hp ();
  hmp_host hmp_host_inst (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hp(hp));
  // Four boot words keep the load short.
  hmp_device #(.BOOT_WORDS(8'h04)) hmp_device_inst (.clk(clk), .sys_rst(sys_rst), .hp(hp),
    .core_addr(core_addr), .core_we(core_we), .core_re(core_re), .core_wdata(core_wdata),
    .core_rdata(core_rdata), .core_wr_irq_en(wen), .core_rd_irq_en(ren), .wr_irq_req(wr_irq_req),
    .rd_irq_req(rd_irq_req), .core_soft_rst(core_soft_rst), .boot_source_select(boot_sel),
    .boot_busy(boot_busy), .boot_from_ext(boot_ext), .pm_we(pm_we), .pm_addr(pm_addr), .pm_data(pm_data));
  hmp_assertions hmp_assertions_inst (.clk(clk), .sys_rst(sys_rst), .width16(hp.width16),
    .strobe_style(hp.strobe_style), .bus_mux(hp.bus_mux), .ale(hp.ale), .rd_rw(hp.rd_rw),
    .wr_ds_n(hp.wr_ds_n), .addr(hp.addr), .hd_h2d(hp.hd_h2d), .hd_h2d_oe(hp.hd_h2d_oe),
    .hd_d2h(hp.hd_d2h), .hd_d2h_oe(hp.hd_d2h_oe));

  // Expected interrupt count: both the mask bit and the global enable must be set.
  function automatic logic [31:0] exp_irq(input logic m, input logic e);
    return {31'h0, m & e};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  // Avalon access; the request holds until waitrequest is seen low.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask

  // Core access; read data is taken one cycle after the request edge.
  task automatic core(input logic we, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    core_addr <= a;
    core_wdata <= d;
    core_we <= we;
    core_re <= !we;
    @(posedge clk);
    core_we <= 1'h0;
    core_re <= 1'h0;
    @(posedge clk);
    q = core_rdata;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Count core-side pulses and cut a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (wr_irq_req === 1'h1) wr_irqs++;
    if (rd_irq_req === 1'h1) rd_irqs++;
    if (core_soft_rst === 1'h1) srst_cyc++;
    if (boot_ext === 1'h1) ext_cyc++;
    if (pm_we === 1'h1) pm_q.push_back({pm_addr, pm_data});
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // Every strap mode, then soft reset from both sides, then host boot.
  initial begin
    int          m;
    int          i;
    logic [15:0] d;
    logic [15:0] mask;
    logic [15:0] c;
    logic [31:0] r;
    logic [31:0] n0;
    n0 = $urandom(96);
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    for (m = 0; m < 8; m++) begin
      i = (m == 0) ? 0 : (m == 7) ? 5 : $urandom_range(5);
      d = (m == 0) ? 16'hFFFF : 16'($urandom);
      mask = (m < 2) ? 16'h3F3F : (m == 2) ? 16'h0 : 16'($urandom) & 16'h3F3F;
      wen <= (m < 3) ? 1'h1 : 1'($urandom);
      ren <= (m < 3) ? 1'h1 : 1'($urandom);
      av(1'h1, A_CFG, 32'(m), r);
      core(1'h1, A_MASK, mask, c);
      n0 = 32'(wr_irqs);
      av(1'h1, 4'(i), {16'h0, d}, r);
      chk(32'(wr_irqs) - n0, exp_irq(mask[WF_LSB + i], wen));
      core(1'h0, A_STAT_LO, 16'h0, c);
      chk({31'h0, c[WF_LSB + i]}, 32'h1);
      core(1'h0, 4'(i), 16'h0, c);
      chk({16'h0, c}, {16'h0, d});
      core(1'h0, A_STAT_LO, 16'h0, c);
      chk({31'h0, c[WF_LSB + i]}, 32'h0);
      d = 16'($urandom);
      core(1'h1, 4'(i), d, c);
      n0 = 32'(rd_irqs);
      av(1'h0, 4'(i), 32'h0, r);
      chk(r, {16'h0, d});
      chk(32'(rd_irqs) - n0, exp_irq(mask[RF_LSB + i], ren));
      av(1'h0, A_STAT_LO, 32'h0, r);
      chk({31'h0, r[RF_LSB + i]}, 32'h1);
    end
    for (m = 0; m < 2; m++) begin
      n0 = 32'(srst_cyc);
      if (m == 0) av(1'h1, A_STAT_HI, 32'h1, r);
      else core(1'h1, A_STAT_HI, 16'h1, c);
      repeat (40) @(posedge clk);
      chk(32'(srst_cyc) - n0, {27'h0, SRST_CYC});
      av(1'h0, A_STAT_HI, 32'h0, r);
      chk({31'h0, r[SRST_BIT]}, 32'h0);
    end
    boot_sel <= 1'h1;
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk({31'h0, boot_busy}, 32'h1);
    for (m = 0; m < 4; m++) av(1'h1, 4'(m), {16'h0, 16'hB000 + 16'(m)}, r);
    repeat (4) @(posedge clk);
    chk({31'h0, boot_busy}, 32'h0);
    chk(32'(pm_q.size()), 32'h4);
    for (m = 0; m < 4; m++) chk({8'h0, pm_q[m]}, {8'h0, 8'(m), 16'hB000 + 16'(m)});
    // External boot flags one cycle after the first reset only, never in host boot.
    chk(32'(ext_cyc), 32'h1);
    end_sim();
  end
endmodule
